// ==== shared/hcd_pkg.sv ====
package hcd_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SOFT_HALL = 8'h04;
	localparam logic [7:0] OFS_FILTER_MODE = 8'h08;
	localparam logic [7:0] OFS_FILTER_COUNT = 8'h0C;
	localparam logic [7:0] OFS_POLARITY = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_GATE_OE = 8'h18;
	localparam logic [7:0] OFS_TABLE = 8'h40;
	localparam int TABLE_ENTRIES = 12;
	localparam int BACKWARD_BASE = 6;
	// Control register fields, then reset value, filter-mode enable bit, drive patterns and unused codes
	localparam int F_DEC_EN = 0;
	localparam int F_DIR = 1;
	localparam int F_BRAKE = 2;
	localparam int F_SRC = 3;
	localparam int F_ANGLE = 4;
	localparam int F_DLY = 5;
	localparam int F_TSEL_LO = 6;
	localparam logic [7:0] CTRL_RESET = 8'h10;
	localparam int F_FILT_EN = 3;
	localparam logic [5:0] DRIVE_BRAKE = 6'h15;
	localparam logic [5:0] DRIVE_OFF = 6'h00;
	localparam logic [2:0] FILT_SEL_UNUSED = 3'h7;
	localparam logic [1:0] TSEL_UNUSED = 2'h3;
endpackage

// ==== design/hcd_noise_filter.sv ====
`timescale 1ns/1ps
module hcd_noise_filter import hcd_pkg::*; #(
	parameter int CHANNELS = 3,
	parameter int CNT_W = 5
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic filter_enable,
	input wire logic [2:0] filter_clock_sel,
	input wire logic [CNT_W-1:0] filter_check_count,
	input wire logic [CHANNELS-1:0] raw_hall_signals,
	output logic [CHANNELS-1:0] filtered
);
	logic [6:0] div_cnt;
	logic [6:0] div_mask;
	logic tick;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01;
		end
	end

	// Sample every 2^(sel+1) clocks; the unused code never samples
	always_comb begin
		div_mask = 7'(({7'h00, 1'b1} << (filter_clock_sel + 3'h1)) - 8'h01);
		tick = (&(div_cnt | ~div_mask)) && (filter_clock_sel != FILT_SEL_UNUSED);
	end

	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_chan
			logic [CNT_W-1:0] agree;
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					filtered[i] <= 1'b0;
					agree <= '0;
				end else if (!filter_enable) begin
					filtered[i] <= raw_hall_signals[i];
					agree <= '0;
				end else if (tick) begin
					if (raw_hall_signals[i] == filtered[i]) begin
						agree <= '0;
					end else if (agree >= filter_check_count) begin
						filtered[i] <= raw_hall_signals[i];
						agree <= '0;
					end else begin
						agree <= agree + 1'b1;
					end
				end
			end
		end
	endgenerate

	chk_filter_bypass: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!filter_enable |=> filtered == $past(raw_hall_signals))
		else $error("bypassed filter did not follow raw input");
endmodule // hcd_noise_filter

// ==== design/hcd_hall_delay.sv ====
`timescale 1ns/1ps
module hcd_hall_delay import hcd_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic delay_path_sel,
	input wire logic [1:0] delay_timer_sel,
	input wire logic [2:0] hall_in,
	input wire logic [2:0] timer_match,
	output logic [2:0] hall_out,
	output logic [2:0] timer_run_bit
);
	logic [2:0] delay_buffer_first;
	logic [2:0] delay_buffer_second;
	logic sel_match;

	assign sel_match = (delay_timer_sel != TSEL_UNUSED) && timer_match[delay_timer_sel];
	assign hall_out = delay_path_sel ? delay_buffer_second : hall_in;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			delay_buffer_first <= 3'h0;
			delay_buffer_second <= 3'h0;
			timer_run_bit <= 3'h0;
		end else if (!delay_path_sel) begin
			delay_buffer_first <= 3'h0;
			delay_buffer_second <= 3'h0;
			timer_run_bit <= 3'h0;
		end else if (hall_in != delay_buffer_first) begin
			// A new step sets the selected run bit; one inside the delay leaves it set, so the timer is not restarted
			delay_buffer_first <= hall_in;
			timer_run_bit <= 3'h0;
			if (delay_timer_sel != TSEL_UNUSED) begin
				timer_run_bit[delay_timer_sel] <= 1'b1;
			end
		end else if (sel_match && timer_run_bit[delay_timer_sel]) begin
			delay_buffer_second <= delay_buffer_first;
			timer_run_bit <= 3'h0;
		end
	end

	chk_buffers_cleared: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!delay_path_sel |=> (delay_buffer_first == 3'h0) && (delay_buffer_second == 3'h0))
		else $error("delay buffers not cleared while bypassed");
	chk_timer_run_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!delay_path_sel |=> timer_run_bit == 3'h0)
		else $error("timer run driven while delay bypassed");
	chk_run_on_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(delay_path_sel && delay_timer_sel == 2'h1 && hall_in != delay_buffer_first)
		|=> timer_run_bit == 3'h2)
		else $error("timer 1 not started on new step");
endmodule // hcd_hall_delay

// ==== design/hcd_top.sv ====
`timescale 1ns/1ps
module hcd_top import hcd_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [2:0] hall_sensor_inputs,
	input wire logic [2:0] timer_match,
	output logic [2:0] timer_run_bit,
	output logic gate_a_top_pin,
	output logic gate_a_top_pin_oe,
	output logic gate_a_bottom_pin,
	output logic gate_a_bottom_pin_oe,
	output logic gate_b_top_pin,
	output logic gate_b_top_pin_oe,
	output logic gate_b_bottom_pin,
	output logic gate_b_bottom_pin_oe,
	output logic gate_c_top_pin,
	output logic gate_c_top_pin_oe,
	output logic gate_c_bottom_pin,
	output logic gate_c_bottom_pin_oe
);
	logic [7:0] ctrl;
	logic [2:0] soft_hall_reg;
	logic [3:0] filter_mode_reg;
	logic [4:0] filter_count_reg;
	logic [5:0] gate_polarity_ctrl;
	logic gate_oe;
	logic [5:0] commutation_entry [TABLE_ENTRIES];
	logic [2:0] filtered_hall;
	logic [2:0] source_hall;
	logic [2:0] decode_hall;
	logic bus_take;
	logic wr_take;
	logic [31:0] next_readdata;
	logic [2:0] step_idx;
	logic step_valid;
	logic [3:0] entry_idx;
	logic [5:0] next_drive;
	logic [5:0] next_guarded;
	logic [5:0] pol_by_drive;
	logic [5:0] decoded_q;
	logic [5:0] guarded_q;

	// Register access: one wait cycle, request completes when waitrequest is low
	assign bus_take = (avs_read || avs_write) && avs_waitrequest;
	assign wr_take = avs_write && !avs_waitrequest;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !bus_take;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= CTRL_RESET;
			soft_hall_reg <= 3'h0;
			filter_mode_reg <= 4'h0;
			filter_count_reg <= 5'h00;
			gate_polarity_ctrl <= 6'h00;
			gate_oe <= 1'b0;
		end else if (wr_take) begin
			case (avs_address)
				OFS_CTRL: ctrl <= avs_writedata[7:0];
				OFS_SOFT_HALL: soft_hall_reg <= avs_writedata[2:0];
				OFS_FILTER_MODE: filter_mode_reg <= avs_writedata[3:0];
				OFS_FILTER_COUNT: filter_count_reg <= avs_writedata[4:0];
				OFS_POLARITY: gate_polarity_ctrl <= avs_writedata[5:0];
				OFS_GATE_OE: gate_oe <= avs_writedata[0];
				default: begin
				end
			endcase
		end
	end

	genvar t;
	generate
		for (t = 0; t < TABLE_ENTRIES; t++) begin : g_entry
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					commutation_entry[t] <= 6'h00;
				end else if (wr_take && avs_address == OFS_TABLE + 8'(4 * t)) begin
					commutation_entry[t] <= avs_writedata[5:0];
				end
			end
		end
	endgenerate

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (avs_address >= OFS_TABLE && avs_address < OFS_TABLE + 8'(4 * TABLE_ENTRIES)
			&& avs_address[1:0] == 2'h0) begin
			next_readdata[5:0] = commutation_entry[4'((avs_address - OFS_TABLE) >> 2)];
		end else begin
			case (avs_address)
				OFS_CTRL: next_readdata[7:0] = ctrl;
				OFS_SOFT_HALL: next_readdata[2:0] = soft_hall_reg;
				OFS_FILTER_MODE: next_readdata[3:0] = filter_mode_reg;
				OFS_FILTER_COUNT: next_readdata[4:0] = filter_count_reg;
				OFS_POLARITY: next_readdata[5:0] = gate_polarity_ctrl;
				OFS_STATUS: next_readdata[11:0] = {decode_hall, step_valid, 2'h0, guarded_q};
				OFS_GATE_OE: next_readdata[0] = gate_oe;
				default: next_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= next_readdata;
		end
	end

	hcd_noise_filter #(
		.CHANNELS(3),
		.CNT_W(5)
	) u_filter (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.filter_enable(filter_mode_reg[F_FILT_EN]),
		.filter_clock_sel(filter_mode_reg[2:0]),
		.filter_check_count(filter_count_reg),
		.raw_hall_signals(hall_sensor_inputs),
		.filtered(filtered_hall)
	);

	// Bit 0 of each vector is sensor A; patterns below are written as {A,B,C}
	assign source_hall = ctrl[F_SRC] ? filtered_hall : soft_hall_reg;

	hcd_hall_delay u_delay (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.delay_path_sel(ctrl[F_DLY]),
		.delay_timer_sel(ctrl[F_TSEL_LO+1:F_TSEL_LO]),
		.hall_in(source_hall),
		.timer_match(timer_match),
		.hall_out(decode_hall),
		.timer_run_bit(timer_run_bit)
	);

	always_comb begin
		step_valid = 1'b1;
		step_idx = 3'h0;
		case ({decode_hall[0], decode_hall[1], decode_hall[2]})
			3'h4: step_idx = 3'h0;
			3'h6: step_idx = 3'h1;
			3'h7: begin
				step_idx = 3'h2;
				step_valid = !ctrl[F_ANGLE];
			end
			3'h2: begin
				step_idx = 3'h2;
				step_valid = ctrl[F_ANGLE];
			end
			3'h3: step_idx = 3'h3;
			3'h1: step_idx = 3'h4;
			3'h0: begin
				step_idx = 3'h5;
				step_valid = !ctrl[F_ANGLE];
			end
			3'h5: begin
				step_idx = 3'h5;
				step_valid = ctrl[F_ANGLE];
			end
			default: step_valid = 1'b0;
		endcase
	end

	assign entry_idx = ctrl[F_DIR] ? 4'(step_idx) + 4'(BACKWARD_BASE) : 4'(step_idx);

	// Brake outranks everything; a one in the pattern means transistor on
	always_comb begin
		if (ctrl[F_BRAKE]) begin
			next_drive = DRIVE_BRAKE;
		end else if (!ctrl[F_DEC_EN]) begin
			next_drive = DRIVE_OFF;
		end else if (!step_valid) begin
			next_drive = DRIVE_OFF;
		end else begin
			next_drive = commutation_entry[entry_idx];
		end
	end

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_pair
			// Both arms on would short the supply, so the pair is dropped entirely
			assign next_guarded[2*p+1] = next_drive[2*p+1] & ~next_drive[2*p];
			assign next_guarded[2*p] = next_drive[2*p] & ~next_drive[2*p+1];
		end
	endgenerate

	// Drive vector runs A top at bit 5; polarity runs A top at bit 0
	assign pol_by_drive = {gate_polarity_ctrl[0], gate_polarity_ctrl[1], gate_polarity_ctrl[2],
		gate_polarity_ctrl[3], gate_polarity_ctrl[4], gate_polarity_ctrl[5]};

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			decoded_q <= 6'h00;
			guarded_q <= 6'h00;
			{gate_a_top_pin, gate_a_bottom_pin, gate_b_top_pin} <= 3'h0;
			{gate_b_bottom_pin, gate_c_top_pin, gate_c_bottom_pin} <= 3'h0;
		end else begin
			decoded_q <= next_drive;
			guarded_q <= next_guarded;
			{gate_a_top_pin, gate_a_bottom_pin, gate_b_top_pin, gate_b_bottom_pin,
				gate_c_top_pin, gate_c_bottom_pin} <= next_guarded ^ pol_by_drive;
		end
	end

	// Pins float until software turns the drivers on
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			{gate_a_top_pin_oe, gate_a_bottom_pin_oe, gate_b_top_pin_oe} <= 3'h0;
			{gate_b_bottom_pin_oe, gate_c_top_pin_oe, gate_c_bottom_pin_oe} <= 3'h0;
		end else begin
			{gate_a_top_pin_oe, gate_a_bottom_pin_oe, gate_b_top_pin_oe} <= {3{gate_oe}};
			{gate_b_bottom_pin_oe, gate_c_top_pin_oe, gate_c_bottom_pin_oe} <= {3{gate_oe}};
		end
	end

	chk_guard_no_short: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!(guarded_q[5] & guarded_q[4]) && !(guarded_q[3] & guarded_q[2])
		&& !(guarded_q[1] & guarded_q[0]))
		else $error("guard let both arms of a pair on");
	chk_brake_pattern: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl[F_BRAKE] |=> guarded_q == DRIVE_BRAKE)
		else $error("brake did not force bottoms on, tops off");
	chk_disable_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!ctrl[F_BRAKE] && !ctrl[F_DEC_EN]) |=> guarded_q == DRIVE_OFF)
		else $error("disabled decoder drove a gate");
	chk_invalid_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!ctrl[F_BRAKE] && !step_valid) |=> decoded_q == DRIVE_OFF)
		else $error("invalid sensor pattern drove a gate");
	chk_backward_table: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!ctrl[F_BRAKE] && ctrl[F_DEC_EN] && ctrl[F_DIR] && step_valid && step_idx == 3'h0)
		|=> decoded_q == $past(commutation_entry[6]))
		else $error("backward first step did not use entry 6");
	chk_polarity_map: assert property (@(posedge clk_sys) disable iff (!reset_n)
		##1 (gate_a_top_pin == (guarded_q[5] ^ $past(gate_polarity_ctrl[0])))
		&& (gate_c_bottom_pin == (guarded_q[0] ^ $past(gate_polarity_ctrl[5]))))
		else $error("gate polarity mapping wrong");
	chk_pins_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!gate_oe |=> !gate_a_top_pin_oe && !gate_c_bottom_pin_oe)
		else $error("gate pin driven while drivers off");
	chk_pol_upper_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(avs_read && avs_waitrequest && avs_address == OFS_POLARITY)
		|=> avs_readdata[31:6] == 26'h0)
		else $error("polarity upper bits not zero");
	chk_soft_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!ctrl[F_SRC] && !ctrl[F_DLY]) |-> decode_hall == soft_hall_reg)
		else $error("software mode did not use software bits");
endmodule // hcd_top

// ==== bench/hcd_partner.sv ====
`timescale 1ns/1ps
module hcd_partner #(
	parameter int DLY = 5
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [2:0] pattern,
	input wire logic [2:0] timer_run_bit,
	output logic [2:0] hall_sensor_inputs,
	output logic [2:0] timer_match
);
	int cnt [3];
	assign hall_sensor_inputs = pattern;
	// Short compare delay keeps the shift well inside one sensor step
	always @(posedge clk_sys or negedge reset_n) begin
		for (int i = 0; i < 3; i++) begin
			if (!reset_n || !timer_run_bit[i]) begin
				cnt[i] <= 0;
				timer_match[i] <= 1'b0;
			end else begin
				cnt[i] <= cnt[i] + 1;
				timer_match[i] <= (cnt[i] == DLY);
			end
		end
	end
endmodule // hcd_partner

// ==== bench/hall_commutation_decoder_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module hall_commutation_decoder_tb import hcd_pkg::*;;
	localparam logic [2:0] ANG60 [6] = '{3'b100, 3'b110, 3'b111, 3'b011, 3'b001, 3'b000};
	localparam logic [2:0] ANG120 [6] = '{3'b100, 3'b110, 3'b010, 3'b011, 3'b001, 3'b101};
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [2:0] pattern = 3'h0;
	logic [2:0] hall_sensor_inputs;
	logic [2:0] timer_match;
	logic [2:0] timer_run_bit;
	wire [5:0] pins;
	wire [5:0] oes;
	logic [5:0] tbl [12];
	logic [5:0] pol;
	logic [5:0] ex;
	logic [7:0] ctrl;
	logic [31:0] rd;
	int errors = 0;
	int comparisons = 0;
	int seed = 32'hffa080bb;
	int n;

	always #10 clk_sys = ~clk_sys;

	hcd_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.hall_sensor_inputs(hall_sensor_inputs), .timer_match(timer_match),
		.timer_run_bit(timer_run_bit),
		.gate_a_top_pin(pins[5]), .gate_a_top_pin_oe(oes[5]),
		.gate_a_bottom_pin(pins[4]), .gate_a_bottom_pin_oe(oes[4]),
		.gate_b_top_pin(pins[3]), .gate_b_top_pin_oe(oes[3]),
		.gate_b_bottom_pin(pins[2]), .gate_b_bottom_pin_oe(oes[2]),
		.gate_c_top_pin(pins[1]), .gate_c_top_pin_oe(oes[1]),
		.gate_c_bottom_pin(pins[0]), .gate_c_bottom_pin_oe(oes[0]));

	hcd_partner #(.DLY(5)) partner (.clk_sys(clk_sys), .reset_n(reset_n), .pattern(pattern),
		.timer_run_bit(timer_run_bit), .hall_sensor_inputs(hall_sensor_inputs),
		.timer_match(timer_match));

	function automatic logic [5:0] model(logic [7:0] c, logic [2:0] h);
		int idx;
		logic [5:0] d;
		idx = -1;
		for (int i = 0; i < 6; i++)
			if ({h[0], h[1], h[2]} == (c[4] ? ANG120[i] : ANG60[i])) idx = i;
		if (c[2]) d = 6'b010101;
		else if (!c[0] || idx < 0) d = 6'h00;
		else d = tbl[idx + (c[1] ? 6 : 0)];
		for (int k = 0; k < 3; k++)
			if (d[2*k+1] && d[2*k]) d[2*k+1 -: 2] = 2'b00;
		return d ^ {pol[0], pol[1], pol[2], pol[3], pol[4], pol[5]};
	endfunction

	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	// Entered just after an edge; request held until waitrequest is seen low
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		int w;
		w = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do begin
			@(posedge clk_sys);
			w++;
		end while (avs_waitrequest !== 1'b0 && w < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			stop_test();
		end
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(a, 1'b0, 32'h0);
		`CHK(nm, e, rd)
	endtask

	task automatic wait_pins(input logic [5:0] e, input int lim);
		int w;
		w = 0;
		while (pins !== e && w < lim) begin
			@(posedge clk_sys);
			w++;
		end
		`CHK("pins in time", e, pins)
	endtask

	initial begin
		cyc(100000);
		errors++;
		stop_test();
	end

	initial begin
		cyc(16);
		reset_n <= 1'b1;
		cyc(2);
		`CHK("oe after reset", 6'h00, oes)
		rdchk(OFS_CTRL, 32'h10, "ctrl reset");
		rdchk(OFS_POLARITY, 32'h0, "polarity reset");
		wr(OFS_POLARITY, 32'hFF);
		rdchk(OFS_POLARITY, 32'h3F, "polarity upper");
		rdchk(8'h3C, 32'h0, "unmapped");
		wr(OFS_GATE_OE, 32'h1);
		cyc(2);
		`CHK("oe enabled", 6'h3F, oes)
		for (int i = 0; i < 12; i++) begin
			tbl[i] = 6'($random(seed));
			wr(OFS_TABLE + 8'(4 * i), 32'(tbl[i]));
			rdchk(OFS_TABLE + 8'(4 * i), 32'(tbl[i]), "table entry");
		end
		// Plain polarity first, then a random inversion mask
		for (int p = 0; p < 2; p++) begin
			pol = p ? 6'($random(seed)) : 6'h00;
			wr(OFS_POLARITY, 32'(pol));
			for (int m = 0; m < 16; m++) begin
				ctrl = {3'b000, m[3], 1'b0, m[2:0]};
				wr(OFS_CTRL, 32'(ctrl));
				for (int h = 0; h < 8; h++) begin
					wr(OFS_SOFT_HALL, 32'(h));
					cyc(2);
					ex = model(ctrl, 3'(h));
					`CHK("soft drive", ex, pins)
				end
			end
		end
		ctrl = 8'h19;
		wr(OFS_CTRL, 32'(ctrl));
		for (int h = 0; h < 8; h++) begin
			pattern <= 3'(h);
			cyc(4);
			`CHK("sensor drive", model(ctrl, 3'(h)), pins)
		end
		for (int f = 0; f < 2; f++) begin
			wr(OFS_FILTER_COUNT, f ? 32'h2 : 32'h4);
			wr(OFS_FILTER_MODE, f ? 32'hA : 32'h8);
			pattern <= 3'h1;
			cyc(80);
			ex = model(ctrl, 3'h1);
			pattern <= 3'h3;
			cyc(1);
			pattern <= 3'h1;
			cyc(40);
			`CHK("glitch held off", ex, pins)
			pattern <= 3'h3;
			// Earliest acceptance is count+1 ticks after the change, then the pin stage
			cyc(f ? 18 : 10);
			`CHK("early change", ex, pins)
			wait_pins(model(ctrl, 3'h3), 12);
		end
		// Unused rate code never samples, so the accepted pattern stays put
		wr(OFS_FILTER_MODE, 32'hF);
		pattern <= 3'h1;
		cyc(300);
		`CHK("unused rate holds", model(ctrl, 3'h3), pins)
		wr(OFS_FILTER_MODE, 32'h0);
		for (int t = 0; t < 3; t++) begin
			wr(OFS_CTRL, 32'h18 | (t << 6));
			pattern <= 3'h1;
			wr(OFS_CTRL, 32'h38 | (t << 6));
			wr(OFS_CTRL, 32'h39 | (t << 6));
			cyc(30);
			ex = model(ctrl, 3'h1);
			`CHK("delayed settle", ex, pins)
			pattern <= 3'h3;
			n = 0;
			while (timer_run_bit === 3'h0 && n < 20) begin
				@(posedge clk_sys);
				n++;
			end
			`CHK("timer run", 3'(1 << t), timer_run_bit)
			`CHK("held for delay", ex, pins)
			wait_pins(model(ctrl, 3'h3), 20);
		end
		// Unused timer code starts nothing, so the delayed pattern holds
		wr(OFS_CTRL, 32'hF9);
		pattern <= 3'h1;
		cyc(30);
		`CHK("unused timer idle", 3'h0, timer_run_bit)
		`CHK("unused timer holds", model(ctrl, 3'h3), pins)
		wr(OFS_CTRL, 32'h19);
		pattern <= 3'h1;
		cyc(4);
		`CHK("bypass again", model(ctrl, 3'h1), pins)
		ex = model(ctrl, 3'h1) ^ {pol[0], pol[1], pol[2], pol[3], pol[4], pol[5]};
		rdchk(OFS_STATUS, {20'h0, 3'h1, 1'b1, 2'h0, ex}, "status");
		stop_test();
	end
endmodule // hall_commutation_decoder_tb
